//--- smacu_params.svh
// smacu_params.svh: register indices, widths and reset values of the
// signed multiply/accumulate unit.
// assumes: included by bare name from every file that needs it.
`ifndef SMACU_PARAMS_SVH
`define SMACU_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SMACU_IDX_PRODUCT_OPERAND_X 8'he8
`define SMACU_IDX_PRODUCT_OPERAND_Y 8'he9
`define SMACU_IDX_PRODUCT_HIGH      8'hea
`define SMACU_IDX_PRODUCT_LOW       8'heb
`define SMACU_IDX_ACCUM_BYTE1       8'hec
`define SMACU_IDX_ACCUM_BYTE0       8'hed
`define SMACU_IDX_ACCUM_BYTE3       8'hee
`define SMACU_IDX_ACCUM_BYTE2       8'hef

// ----------------------------------------------------------------------
// address layout
// ----------------------------------------------------------------------
`define SMACU_PADDR_W     12
`define SMACU_IDX_LSB     2
`define SMACU_IDX_MSB     9
`define SMACU_UPPER_LSB   10
`define SMACU_UPPER_ZERO  2'h0
`define SMACU_ALIGN_ZERO  2'h0

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define SMACU_DATA_W      32
`define SMACU_OPERAND_W   8
`define SMACU_HALF_W      16
`define SMACU_RESET_BYTE  8'h00
`define SMACU_RESET_HALF  16'h0000
`define SMACU_RESET_WORD  32'h0000_0000
`define SMACU_PAD_24      24'h00_0000

`endif

//--- smacu_pkg.sv
// smacu_pkg.sv: types shared by the multiply/accumulate unit.
// assumes: compiled before the design modules.
package smacu_pkg;

    // ------------------------------------------------------------------
    // decoded register select, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [8:0] {
        SMACU_SEL_NONE  = 9'h001,
        SMACU_SEL_PRODUCT_OPERAND_X = 9'h002,
        SMACU_SEL_PRODUCT_OPERAND_Y = 9'h004,
        SMACU_SEL_PHIGH = 9'h008,
        SMACU_SEL_PLOW  = 9'h010,
        SMACU_SEL_ACC1  = 9'h020,
        SMACU_SEL_ACC0  = 9'h040,
        SMACU_SEL_ACC3  = 9'h080,
        SMACU_SEL_ACC2  = 9'h100
    } smacu_sel_t;

    typedef logic [7:0]         smacu_byte_t;
    typedef logic signed [15:0] smacu_half_t;

endpackage : smacu_pkg

//--- smacu_add_slice.sv
// smacu_add_slice.sv: one slice of the split accumulator adder.
// assumes: purely combinational, registered by the caller.
`timescale 1ns/1ps
`default_nettype none

module smacu_add_slice #(
    parameter int W = 16
) (
    // operands
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    input  wire logic         cin,
    // result
    output logic      [W-1:0] sum,
    output logic              cout
);

    logic [W:0] full;

    assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    assign sum  = full[W-1:0];
    assign cout = full[W];

endmodule : smacu_add_slice

`default_nettype wire

//--- smacu_top.sv
// smacu_top.sv: signed 8x8 multiplier with 32-bit accumulator, APB slave.
// assumes: one clock pclk at 40 MHz, asynchronous active-low presetn,
// an APB master that keeps one access between accumulate writes.
//
// Overview of operation
// - four operand registers each take an 8-bit signed value.
// - product high and low bytes give the full 16-bit signed product.
// - four accumulator bytes hold a 32-bit signed accumulation.
// - multiply-only operand write updates the product, accumulator untouched.
// - accumulate operand write multiplies and adds product to accumulator.
// - both X write registers load the one shared X operand.
// - both Y write registers load the one shared Y operand.
// - any write to either clear register zeroes all accumulator bytes.
// - product and low accumulator bytes ready at once, upper one access later.
// - unit is reached as ordinary registers on the register bus.
// - accumulator byte 0 reads bits 7:0, written it is accumulate Y.
// - accumulator byte 1 reads bits 15:8, written it is accumulate X.
`timescale 1ns/1ps
`default_nettype none
`include "smacu_params.svh"

module smacu_top (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb request
    input  wire logic [`SMACU_PADDR_W-1:0]   paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`SMACU_DATA_W-1:0]    pwdata,
    input  wire logic [3:0]                  pstrb,
    // apb answer
    output logic      [`SMACU_DATA_W-1:0]    prdata,
    output logic                             pready,
    output logic                             pslverr
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    smacu_pkg::smacu_byte_t op_x;
    smacu_pkg::smacu_byte_t op_y;
    smacu_pkg::smacu_half_t product;
    logic [`SMACU_HALF_W-1:0] acc_lo;
    logic [`SMACU_HALF_W-1:0] acc_hi;
    logic [`SMACU_HALF_W-1:0] hi_addend;
    logic                     hi_carry;
    logic                     hi_pending;
    logic [`SMACU_DATA_W-1:0] rdata_q;

    smacu_pkg::smacu_byte_t   next_op_x;
    smacu_pkg::smacu_byte_t   next_op_y;
    smacu_pkg::smacu_half_t   next_product;
    logic [`SMACU_HALF_W-1:0] next_acc_lo;
    logic [`SMACU_HALF_W-1:0] next_acc_hi;
    logic [`SMACU_HALF_W-1:0] next_hi_addend;
    logic                     next_hi_carry;
    logic                     next_hi_pending;
    logic [`SMACU_DATA_W-1:0] next_rdata_q;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    smacu_pkg::smacu_sel_t    sel;
    logic                     setup_ph;
    logic                     access_ph;
    logic                     wr_acc;
    logic                     wr_x;
    logic                     wr_y;
    logic                     mac_wr;
    logic                     clr_wr;

    always_comb begin
        sel = smacu_pkg::SMACU_SEL_NONE;
        if (paddr[`SMACU_PADDR_W-1:`SMACU_UPPER_LSB] == `SMACU_UPPER_ZERO &&
            paddr[`SMACU_IDX_LSB-1:0] == `SMACU_ALIGN_ZERO) begin
            unique case (paddr[`SMACU_IDX_MSB:`SMACU_IDX_LSB])
                `SMACU_IDX_PRODUCT_OPERAND_X: sel = smacu_pkg::SMACU_SEL_PRODUCT_OPERAND_X;
                `SMACU_IDX_PRODUCT_OPERAND_Y: sel = smacu_pkg::SMACU_SEL_PRODUCT_OPERAND_Y;
                `SMACU_IDX_PRODUCT_HIGH:      sel = smacu_pkg::SMACU_SEL_PHIGH;
                `SMACU_IDX_PRODUCT_LOW:       sel = smacu_pkg::SMACU_SEL_PLOW;
                `SMACU_IDX_ACCUM_BYTE1:       sel = smacu_pkg::SMACU_SEL_ACC1;
                `SMACU_IDX_ACCUM_BYTE0:       sel = smacu_pkg::SMACU_SEL_ACC0;
                `SMACU_IDX_ACCUM_BYTE3:       sel = smacu_pkg::SMACU_SEL_ACC3;
                `SMACU_IDX_ACCUM_BYTE2:       sel = smacu_pkg::SMACU_SEL_ACC2;
                default:                      sel = smacu_pkg::SMACU_SEL_NONE;
            endcase
        end
    end

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_acc    = access_ph & pwrite & (sel != smacu_pkg::SMACU_SEL_NONE);

    // shared operands, either register of a pair loads the same one
    assign wr_x   = wr_acc & pstrb[0] & ((sel == smacu_pkg::SMACU_SEL_PRODUCT_OPERAND_X) |
                                         (sel == smacu_pkg::SMACU_SEL_ACC1));
    assign wr_y   = wr_acc & pstrb[0] & ((sel == smacu_pkg::SMACU_SEL_PRODUCT_OPERAND_Y) |
                                         (sel == smacu_pkg::SMACU_SEL_ACC0));
    assign mac_wr = wr_acc & pstrb[0] & ((sel == smacu_pkg::SMACU_SEL_ACC1) |
                                         (sel == smacu_pkg::SMACU_SEL_ACC0));
    assign clr_wr = wr_acc & ((sel == smacu_pkg::SMACU_SEL_ACC3) |
                              (sel == smacu_pkg::SMACU_SEL_ACC2));

    // ------------------------------------------------------------------
    // multiplier and split adder
    // ------------------------------------------------------------------
    smacu_pkg::smacu_half_t   prod_calc;
    logic [`SMACU_DATA_W-1:0] prod_ext;
    logic [`SMACU_HALF_W-1:0] lo_sum;
    logic                     lo_cout;
    logic [`SMACU_HALF_W-1:0] hi_sum;

    assign next_op_x = wr_x ? pwdata[`SMACU_OPERAND_W-1:0] : op_x;
    assign next_op_y = wr_y ? pwdata[`SMACU_OPERAND_W-1:0] : op_y;
    assign prod_calc = $signed(next_op_x) * $signed(next_op_y);
    assign prod_ext  = {{`SMACU_HALF_W{prod_calc[`SMACU_HALF_W-1]}}, prod_calc};

    smacu_add_slice #(
        .W    (`SMACU_HALF_W)
    ) u_add_lo (
        .a    (acc_lo),
        .b    (prod_ext[`SMACU_HALF_W-1:0]),
        .cin  (1'b0),
        .sum  (lo_sum),
        .cout (lo_cout)
    );

    smacu_add_slice #(
        .W    (`SMACU_HALF_W)
    ) u_add_hi (
        .a    (acc_hi),
        .b    (hi_addend),
        .cin  (hi_carry),
        .sum  (hi_sum),
        .cout ()
    );

    // ------------------------------------------------------------------
    // next state of operands, product and accumulator
    // ------------------------------------------------------------------
    always_comb begin
        next_product    = product;
        next_acc_lo     = acc_lo;
        next_acc_hi     = acc_hi;
        next_hi_addend  = hi_addend;
        next_hi_carry   = hi_carry;
        next_hi_pending = 1'b0;
        if (wr_x | wr_y) begin
            next_product = prod_calc;
        end
        // upper half lands one cycle after the low half
        if (hi_pending) begin
            next_acc_hi = hi_sum;
        end
        if (mac_wr) begin
            next_acc_lo     = lo_sum;
            next_hi_addend  = prod_ext[`SMACU_DATA_W-1:`SMACU_HALF_W];
            next_hi_carry   = lo_cout;
            next_hi_pending = 1'b1;
        end
        if (clr_wr) begin
            next_acc_lo     = `SMACU_RESET_HALF;
            next_acc_hi     = `SMACU_RESET_HALF;
            next_hi_pending = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata_q = rdata_q;
        if (setup_ph & ~pwrite) begin
            unique case (sel)
                smacu_pkg::SMACU_SEL_PHIGH:
                    next_rdata_q = {`SMACU_PAD_24, product[15:8]};
                smacu_pkg::SMACU_SEL_PLOW:
                    next_rdata_q = {`SMACU_PAD_24, product[7:0]};
                smacu_pkg::SMACU_SEL_ACC0:
                    next_rdata_q = {`SMACU_PAD_24, acc_lo[7:0]};
                smacu_pkg::SMACU_SEL_ACC1:
                    next_rdata_q = {`SMACU_PAD_24, acc_lo[15:8]};
                smacu_pkg::SMACU_SEL_ACC2:
                    next_rdata_q = {`SMACU_PAD_24, acc_hi[7:0]};
                smacu_pkg::SMACU_SEL_ACC3:
                    next_rdata_q = {`SMACU_PAD_24, acc_hi[15:8]};
                smacu_pkg::SMACU_SEL_PRODUCT_OPERAND_X,
                smacu_pkg::SMACU_SEL_PRODUCT_OPERAND_Y,
                smacu_pkg::SMACU_SEL_NONE:
                    next_rdata_q = `SMACU_RESET_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_x       <= `SMACU_RESET_BYTE;
            op_y       <= `SMACU_RESET_BYTE;
            product    <= `SMACU_RESET_HALF;
            acc_lo     <= `SMACU_RESET_HALF;
            acc_hi     <= `SMACU_RESET_HALF;
            hi_addend  <= `SMACU_RESET_HALF;
            hi_carry   <= 1'b0;
            hi_pending <= 1'b0;
            rdata_q    <= `SMACU_RESET_WORD;
        end else begin
            op_x       <= next_op_x;
            op_y       <= next_op_y;
            product    <= next_product;
            acc_lo     <= next_acc_lo;
            acc_hi     <= next_acc_hi;
            hi_addend  <= next_hi_addend;
            hi_carry   <= next_hi_carry;
            hi_pending <= next_hi_pending;
            rdata_q    <= next_rdata_q;
        end
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = access_ph & (sel == smacu_pkg::SMACU_SEL_NONE);

endmodule : smacu_top

`default_nettype wire

//--- smacu_top_asserts.sv
// smacu_top_asserts.sv: port-level checks of the multiply/accumulate unit.
// assumes: bound to smacu_top; one clock pclk, reset presetn.
`timescale 1ns/1ps
`default_nettype none
module smacu_top_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb request
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // transfer steps
    // ------------------------------------------------------------------
    sequence s_rd(a, b);
        psel && !penable && !pwrite && paddr inside {a, b} ##1 psel && penable;
    endsequence
    sequence s_clr;
        psel && penable && pwrite && paddr inside {12'h3b8, 12'h3bc};
    endsequence
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (psel && penable && paddr[11:10] != 2'h0 |-> pslverr)
        else $error("unmapped access without error");
    a_err_mapped: assert property (psel && penable && paddr inside {[12'h3a0:12'h3bc]}
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("mapped access flagged");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access phase");
    a_rdata_byte: assert property (prdata[31:8] == 24'h0)
        else $error("read data above byte");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without read");
    a_opreg_zero: assert property (s_rd(12'h3a0, 12'h3a4) |-> prdata == 32'h0)
        else $error("operand register read not zero");
    a_unmapped_rd: assert property (psel && !penable && !pwrite && paddr[11:10] != 2'h0
        ##1 psel && penable |-> prdata == 32'h0) else $error("unmapped read data");
    a_clear_low: assert property (s_clr ##1 s_rd(12'h3b0, 12'h3b4) |-> prdata == 32'h0)
        else $error("low bytes after clear");
    a_clear_high: assert property (s_clr ##1 s_rd(12'h3b8, 12'h3bc) |-> prdata == 32'h0)
        else $error("high bytes after clear");
endmodule : smacu_top_asserts
bind smacu_top smacu_top_asserts smacu_top_asserts_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- smacu_cpu_model.sv
// smacu_cpu_model.sv: cpu side of the register bus, an apb master.
// assumes: tasks are called right after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module smacu_cpu_model (
    // clock
    input  wire logic        pclk,
    // apb request
    output var  logic [11:0] paddr,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    // apb answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {paddr, psel, penable, pwrite, pwdata, pstrb} = '0;
    end
    // one transfer; the request stays up afterwards for a direct next setup
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] r, output logic e,
                        output logic ok);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            r  = prdata;
            e  = pslverr;
        end
    endtask : xfer
    // release the bus; address and write data are inverted, pwrite and pstrb are left as they were
    task automatic idle;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~paddr;
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask : idle
endmodule : smacu_cpu_model
`default_nettype wire

//--- tb_signed_multiply_accumulate_unit.sv
// tb_signed_multiply_accumulate_unit.sv: self-checking bench of the unit.
// assumes: design, cpu model and checker compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x, m) begin checks_done++; if ((g) !== (x)) begin err_count++; $display("wrong value at %0t: %s", $time, m); end end
module tb_signed_multiply_accumulate_unit;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          err_count = 0;
    int          checks_done = 0;
    localparam logic [11:0] a_x = 12'h3a0, a_y = 12'h3a4, a_ph = 12'h3a8, a_pl = 12'h3ac;
    localparam logic [11:0] a_c1 = 12'h3b0, a_c0 = 12'h3b4, a_c3 = 12'h3b8, a_c2 = 12'h3bc;
    localparam logic [7:0]  xs [4] = '{8'h80, 8'h80, 8'hff, 8'h7f};
    localparam logic [7:0]  ys [4] = '{8'h80, 8'h7f, 8'h01, 8'h7f};
    always #12.5 pclk = ~pclk;
    smacu_top smacu_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    smacu_cpu_model smacu_cpu_model_inst (.pclk(pclk), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ------------------------------------------------------------------
    // bus helpers
    // ------------------------------------------------------------------
    task automatic results;
        $display("mismatches %0d, comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
        logic ok;
        smacu_cpu_model_inst.xfer(w, a, {24'h0, d}, s, r, e, ok);
        if (!ok) begin
            err_count++;
            results();
        end
    endtask : xf
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        xf(1'b1, a, d, 4'h1, r, e);
        `CHK(e, 1'b0, "write flagged")
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        xf(1'b0, a, 8'h00, 4'h0, r, e);
        `CHK(e, 1'b0, "read flagged")
    endtask : rd
    function automatic logic [31:0] mul(input logic [7:0] a, input logic [7:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        return p;
    endfunction : mul
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            rd(a_x + 12'(4 * i), r);
            `CHK(r, 32'h0, "reset value")
        end
    endtask : t_reset
    task automatic t_mul;
        logic [31:0] h, l;
        for (int i = 0; i < 4; i++) begin
            wr(a_x, xs[i]);
            wr(a_y, ys[i]);
            rd(a_ph, h);
            rd(a_pl, l);
            `CHK({h[7:0], l[7:0]}, mul(xs[i], ys[i]) & 32'hffff, "product")
            rd(a_c0, l);
            `CHK(l, 32'h0, "accumulator moved")
        end
    endtask : t_mul
    task automatic t_mac;
        logic [31:0] acc, r;
        acc = 32'h0;
        for (int i = 3; i >= 0; i--) begin
            if (i % 2 == 1) begin
                wr(a_y, ys[i]);
                wr(a_c1, xs[i]);
            end else begin
                wr(a_x, xs[i]);
                wr(a_c0, ys[i]);
            end
            acc = acc + mul(xs[i], ys[i]);
            rd(a_c0, r);
            `CHK(r[7:0], acc[7:0], "acc byte0")
            rd(a_c1, r);
            `CHK(r[7:0], acc[15:8], "acc byte1")
            rd(a_c3, r);
            `CHK(r[7:0], acc[31:24], "acc byte3")
            rd(a_c2, r);
            `CHK(r[7:0], acc[23:16], "acc byte2")
            rd(a_pl, r);
            `CHK(r[7:0], mul(xs[i], ys[i]) & 32'hff, "shared operands")
        end
    endtask : t_mac
    task automatic t_clear;
        logic [31:0] r;
        logic        e;
        wr(a_c3, 8'h5a);
        for (int i = 4; i < 8; i++) begin
            rd(a_x + 12'(4 * i), r);
            `CHK(r, 32'h0, "clear a")
        end
        wr(a_x, 8'h02);
        wr(a_c0, 8'hfd);
        rd(a_c1, r);
        xf(1'b1, a_c2, 8'h00, 4'h0, r, e);
        rd(a_c3, r);
        `CHK(r, 32'h0, "clear b")
        rd(a_c0, r);
        `CHK(r, 32'h0, "clear b low")
    endtask : t_clear
    task automatic t_refuse;
        logic [31:0] r;
        logic        e;
        xf(1'b0, 12'h400, 8'h00, 4'h0, r, e);
        `CHK({e, r}, {1'b1, 32'h0}, "unmapped read")
        wr(a_ph, 8'h12);
        rd(a_ph, r);
        `CHK(r, 32'hff, "product write ignored")
        xf(1'b1, a_x + 12'h001, 8'h07, 4'h1, r, e);
        `CHK(e, 1'b1, "misaligned write")
        xf(1'b1, a_x, 8'h05, 4'h0, r, e);
        wr(a_y, 8'h03);
        rd(a_ph, r);
        `CHK(r, 32'h0, "product high")
        rd(a_pl, r);
        `CHK(r, 32'h6, "product low")
    endtask : t_refuse
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_mul();
        smacu_cpu_model_inst.idle();
        t_mac();
        t_clear();
        t_refuse();
        smacu_cpu_model_inst.idle();
        results();
    end
endmodule : tb_signed_multiply_accumulate_unit
`default_nettype wire
